// ==== src/lpp_defines.svh ====
// timing counts, widths and depths of the parallel port engine
`ifndef LPP_DEFINES_SVH
`define LPP_DEFINES_SVH
`define LPP_DATA_W 8
`define LPP_FIFO_DEPTH 32
`define LPP_CLK_PERIOD_NS 10
`define LPP_SETUP_NS 500
`define LPP_STROBE_NS 500
`define LPP_HOLD_NS 500
`define LPP_EPP_TIMEOUT_NS 10000
`define LPP_SETUP_CYC ((`LPP_SETUP_NS + `LPP_CLK_PERIOD_NS - 1) / `LPP_CLK_PERIOD_NS)
`define LPP_STROBE_CYC ((`LPP_STROBE_NS + `LPP_CLK_PERIOD_NS - 1) / `LPP_CLK_PERIOD_NS)
`define LPP_HOLD_CYC ((`LPP_HOLD_NS + `LPP_CLK_PERIOD_NS - 1) / `LPP_CLK_PERIOD_NS)
`define LPP_EPP_TIMEOUT_CYC (`LPP_EPP_TIMEOUT_NS / `LPP_CLK_PERIOD_NS)
`define LPP_CNT_W 11
`endif

// ==== src/lpp_pkg.sv ====
// types shared by the parallel port engine and its bench
package lpp_pkg;
  typedef enum logic [2:0] {
    LPP_OP_SPP_WR,
    LPP_OP_EPP_DWR,
    LPP_OP_EPP_AWR,
    LPP_OP_EPP_DRD,
    LPP_OP_EPP_ARD
  } lpp_op_t;
  typedef struct packed {
    lpp_op_t op;
    logic [7:0] data;
  } lpp_cmd_t;
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_SPP_BUSY,
    ST_SPP_SETUP,
    ST_SPP_STROBE,
    ST_SPP_HOLD,
    ST_EPP_STRB,
    ST_EPP_END
  } lpp_state_t;
endpackage

// ==== src/lpp_stream_if.sv ====
// valid/ready stream carrying commands from the fifo to the engine
`timescale 1ns/100ps
`default_nettype none
interface lpp_stream_if #(parameter int W = 11);
  logic valid;
  logic ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

// ==== src/lpp_fifo.sv ====
// synchronous command fifo with valid/ready on both sides
`timescale 1ns/100ps
`default_nettype none
module lpp_fifo #(
  parameter int WIDTH = 11,
  parameter int DEPTH = 32
) (
  input wire logic clk_sys_i,
  input wire logic rstn_i,
  input wire logic ce_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  lpp_stream_if.src out
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  logic push;
  logic pop;
  logic [AW:0] next_count;
  // ==========================================
  // push/pop and occupancy
  assign push = ce_i && in_valid_i && in_ready_o;
  assign pop = ce_i && out.valid && out.ready;
  assign next_count = count + (AW+1)'(push) - (AW+1)'(pop);
  assign out.data = mem[rd_ptr];
  // pointers and flags, in_ready stalls the source when full
  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
      in_ready_o <= 1'b0;
      out.valid <= 1'b0;
    end else if (ce_i) begin
      if (push) wr_ptr <= AW'(wr_ptr + 1'b1);
      if (pop) rd_ptr <= AW'(rd_ptr + 1'b1);
      count <= next_count;
      in_ready_o <= (next_count != (AW+1)'(DEPTH));
      out.valid <= (next_count != '0);
    end
  end
  // storage
  always_ff @(posedge clk_sys_i) begin
    if (push) mem[wr_ptr] <= in_data_i;
  end
endmodule
`default_nettype wire

// ==== src/lpp_port.sv ====
// parallel port engine: compatibility and EPP pin handling behind a command fifo
// What this block does
// - in EPP mode the same input is the attention signal, same meaning
// - in EPP mode the handshake input paces every address and data cycle
// - compatibility mode: host-select is open-drain, asserted to select peripheral
// - EPP mode: host-select pin becomes address strobe for reads and writes
// - initialise output: open-drain in compatibility, push-pull in EPP
// - compatibility mode: auto-linefeed is open-drain
// - EPP mode: auto-linefeed pin becomes data strobe for reads and writes
// - compatibility mode: strobe pulses while a valid byte is on the bus
// - EPP mode: direction output low for write, high for read
// - drive-enable high while data lines output, low while input
// - strap 1 enables this port as function 1, strap 0 leaves it off
`include "lpp_defines.svh"
`timescale 1ns/100ps
`default_nettype none
module lpp_port (
  input wire logic clk_sys_i,
  input wire logic rstn_i,
  input wire logic ce_i,
  input wire logic mode_strap_i,
  input wire logic epp_mode_i,
  input wire logic select_req_i,
  input wire logic init_req_i,
  input wire logic auto_linefeed_i,
  input wire logic cmd_valid_i,
  input wire lpp_pkg::lpp_op_t cmd_op_i,
  input wire logic [7:0] cmd_data_i,
  output logic cmd_ready_o,
  output logic done_o,
  output logic timeout_o,
  output logic rd_valid_o,
  output logic [7:0] rd_data_o,
  output logic port_enable_o,
  output logic paper_out_o,
  output logic online_o,
  output logic fault_o,
  output logic not_ready_o,
  output logic attention_o,
  output logic attention_evt_o,
  input wire logic epp_attention_n_i,
  input wire logic paper_out_i,
  input wire logic wait_busy_i,
  input wire logic peripheral_online_i,
  input wire logic fault_n_i,
  output logic host_select_n_o,
  output logic host_select_n_oe_o,
  output logic init_n_o,
  output logic init_n_oe_o,
  output logic auto_linefeed_n_o,
  output logic auto_linefeed_n_oe_o,
  output logic data_latch_strobe_n_o,
  output logic data_latch_strobe_n_oe_o,
  input wire logic [7:0] port_data_i,
  output logic [7:0] port_data_o,
  output logic port_data_oe_o,
  output logic port_drive_enable_o
);
  import lpp_pkg::*;
  localparam int CW = `LPP_CNT_W;
  localparam int CMD_W = $bits(lpp_cmd_t);
  localparam logic [CW-1:0] SETUP_CYC = CW'(`LPP_SETUP_CYC);
  localparam logic [CW-1:0] STROBE_CYC = CW'(`LPP_STROBE_CYC);
  localparam logic [CW-1:0] HOLD_CYC = CW'(`LPP_HOLD_CYC);
  localparam logic [CW-1:0] EPP_TO_CYC = CW'(`LPP_EPP_TIMEOUT_CYC);

  lpp_stream_if #(.W(CMD_W)) cmd_if ();
  lpp_state_t state;
  lpp_cmd_t cur;
  lpp_cmd_t head;
  logic strap_taken;
  logic epp_q;
  logic [CW-1:0] cnt;
  logic att_q;
  logic wait_q;
  logic drive;
  logic addr_stb;
  logic data_stb;
  logic spp_stb;
  logic dir_read;

  // ==========================================
  // command fifo
  lpp_fifo #(.WIDTH(CMD_W), .DEPTH(`LPP_FIFO_DEPTH)) u_fifo (
    .clk_sys_i(clk_sys_i),
    .rstn_i(rstn_i),
    .ce_i(ce_i),
    .in_valid_i(cmd_valid_i),
    .in_ready_o(cmd_ready_o),
    .in_data_i({cmd_op_i, cmd_data_i}),
    .out(cmd_if.src)
  );
  assign head = lpp_cmd_t'(cmd_if.data);
  assign cmd_if.ready = (state == ST_IDLE) && port_enable_o;

  function automatic logic is_read(input lpp_op_t op);
    is_read = (op == LPP_OP_EPP_DRD) || (op == LPP_OP_EPP_ARD);
  endfunction
  function automatic logic is_addr(input lpp_op_t op);
    is_addr = (op == LPP_OP_EPP_AWR) || (op == LPP_OP_EPP_ARD);
  endfunction

  // ==========================================
  // strap capture, once after reset release
  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      strap_taken <= 1'b0;
      port_enable_o <= 1'b0;
    end else if (ce_i && !strap_taken) begin
      strap_taken <= 1'b1;
      port_enable_o <= mode_strap_i;
    end
  end

  // ==========================================
  // status inputs, sampled every cycle and reported
  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      att_q <= 1'b1;
      wait_q <= 1'b0;
      paper_out_o <= 1'b0;
      online_o <= 1'b0;
      fault_o <= 1'b0;
      not_ready_o <= 1'b0;
      attention_o <= 1'b0;
      attention_evt_o <= 1'b0;
    end else if (ce_i) begin
      att_q <= epp_attention_n_i;
      wait_q <= wait_busy_i;
      paper_out_o <= paper_out_i;
      online_o <= peripheral_online_i;
      fault_o <= !fault_n_i;
      not_ready_o <= wait_busy_i && !epp_q;
      attention_o <= !att_q;
      attention_evt_o <= att_q && !epp_attention_n_i;
    end
  end

  // ==========================================
  // transfer sequencer
  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      state <= ST_IDLE;
      cur <= '0;
      cnt <= '0;
      epp_q <= 1'b0;
      drive <= 1'b0;
      addr_stb <= 1'b0;
      data_stb <= 1'b0;
      spp_stb <= 1'b0;
      dir_read <= 1'b0;
      done_o <= 1'b0;
      timeout_o <= 1'b0;
      rd_valid_o <= 1'b0;
      rd_data_o <= '0;
    end else if (ce_i) begin
      done_o <= 1'b0;
      timeout_o <= 1'b0;
      rd_valid_o <= 1'b0;
      case (state)
        ST_IDLE: begin
          epp_q <= epp_mode_i;
          if (cmd_if.valid && cmd_if.ready) begin
            cur <= head;
            cnt <= '0;
            if (epp_mode_i) begin
              dir_read <= is_read(head.op);
              drive <= !is_read(head.op);
              addr_stb <= is_addr(head.op);
              data_stb <= !is_addr(head.op);
              state <= ST_EPP_STRB;
            end else if (is_read(head.op)) begin
              rd_data_o <= port_data_i;
              rd_valid_o <= 1'b1;
              done_o <= 1'b1;
            end else begin
              state <= ST_SPP_BUSY;
            end
          end
        end
        ST_SPP_BUSY: begin
          if (!wait_q) begin
            drive <= 1'b1;
            state <= ST_SPP_SETUP;
          end
        end
        ST_SPP_SETUP: begin
          cnt <= CW'(cnt + 1'b1);
          if (cnt == SETUP_CYC - 1'b1) begin
            cnt <= '0;
            spp_stb <= 1'b1;
            state <= ST_SPP_STROBE;
          end
        end
        ST_SPP_STROBE: begin
          cnt <= CW'(cnt + 1'b1);
          if (cnt == STROBE_CYC - 1'b1) begin
            cnt <= '0;
            spp_stb <= 1'b0;
            state <= ST_SPP_HOLD;
          end
        end
        ST_SPP_HOLD: begin
          cnt <= CW'(cnt + 1'b1);
          if (cnt == HOLD_CYC - 1'b1) begin
            drive <= 1'b0;
            done_o <= 1'b1;
            state <= ST_IDLE;
          end
        end
        ST_EPP_STRB: begin
          cnt <= CW'(cnt + 1'b1);
          if (wait_q || cnt == EPP_TO_CYC) begin
            if (dir_read && wait_q) begin
              rd_data_o <= port_data_i;
              rd_valid_o <= 1'b1;
            end
            timeout_o <= !wait_q;
            addr_stb <= 1'b0;
            data_stb <= 1'b0;
            cnt <= '0;
            state <= ST_EPP_END;
          end
        end
        ST_EPP_END: begin
          cnt <= CW'(cnt + 1'b1);
          if (!wait_q || cnt == EPP_TO_CYC) begin
            drive <= 1'b0;
            dir_read <= 1'b0;
            done_o <= 1'b1;
            state <= ST_IDLE;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // ==========================================
  // pin stage: control pins open-drain in compatibility mode, push-pull in EPP mode; data lines push-pull in both
  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      host_select_n_o <= 1'b0;
      host_select_n_oe_o <= 1'b0;
      init_n_o <= 1'b0;
      init_n_oe_o <= 1'b0;
      auto_linefeed_n_o <= 1'b0;
      auto_linefeed_n_oe_o <= 1'b0;
      data_latch_strobe_n_o <= 1'b0;
      data_latch_strobe_n_oe_o <= 1'b0;
      port_data_o <= '0;
      port_data_oe_o <= 1'b0;
      port_drive_enable_o <= 1'b0;
    end else if (ce_i) begin
      if (!port_enable_o) begin
        host_select_n_oe_o <= 1'b0;
        init_n_oe_o <= 1'b0;
        auto_linefeed_n_oe_o <= 1'b0;
        data_latch_strobe_n_oe_o <= 1'b0;
      end else if (epp_q) begin
        host_select_n_o <= !addr_stb;
        host_select_n_oe_o <= 1'b1;
        init_n_o <= !init_req_i;
        init_n_oe_o <= 1'b1;
        auto_linefeed_n_o <= !data_stb;
        auto_linefeed_n_oe_o <= 1'b1;
        data_latch_strobe_n_o <= dir_read;
        data_latch_strobe_n_oe_o <= 1'b1;
      end else begin
        host_select_n_o <= 1'b0;
        host_select_n_oe_o <= select_req_i;
        init_n_o <= 1'b0;
        init_n_oe_o <= init_req_i;
        auto_linefeed_n_o <= 1'b0;
        auto_linefeed_n_oe_o <= auto_linefeed_i;
        data_latch_strobe_n_o <= 1'b0;
        data_latch_strobe_n_oe_o <= spp_stb;
      end
      port_data_o <= cur.data;
      port_data_oe_o <= drive && port_enable_o;
      port_drive_enable_o <= drive && port_enable_o;
    end
  end

  // ==========================================
  // assertions
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rstn_i);

  AST_DIR_NO_DRIVE: assert property (
    (data_latch_strobe_n_oe_o && data_latch_strobe_n_o) |-> !port_drive_enable_o)
    else $error("data lines driven during a read cycle");
  AST_SPP_STB_DATA: assert property (
    (!$past(epp_q) && data_latch_strobe_n_oe_o) |-> (port_drive_enable_o && data_latch_strobe_n_o == 1'b0))
    else $error("strobe pulsed without a driven byte");
  AST_ADDR_STB_OP: assert property (
    ($past(epp_q) && host_select_n_oe_o && !host_select_n_o) |-> is_addr(cur.op))
    else $error("address strobe on a data cycle");
  AST_DATA_STB_OP: assert property (
    ($past(epp_q) && auto_linefeed_n_oe_o && !auto_linefeed_n_o) |-> !is_addr(cur.op))
    else $error("data strobe on an address cycle");
  AST_EPP_PACED: assert property (
    (ce_i && state == ST_EPP_STRB && wait_q) |=> (state == ST_EPP_END && !addr_stb && !data_stb))
    else $error("strobe not released after handshake");
  AST_EPP_HELD: assert property (
    (ce_i && state == ST_EPP_STRB && !wait_q && cnt < EPP_TO_CYC) |=> state == ST_EPP_STRB)
    else $error("strobe released without handshake");
  AST_STRAP_STABLE: assert property (
    (strap_taken && $past(strap_taken)) |-> $stable(port_enable_o))
    else $error("port enable changed after strap capture");
  AST_STRAP_OFF: assert property (
    !port_enable_o |-> ##1 (!port_drive_enable_o && !host_select_n_oe_o && !init_n_oe_o))
    else $error("pins driven while the port is disabled");
  AST_ATTN_EVT: assert property (
    (ce_i && att_q && !epp_attention_n_i) |=> attention_evt_o)
    else $error("attention edge not reported");
  AST_INIT_OD: assert property (
    (ce_i && port_enable_o && !epp_q) |=> (init_n_o == 1'b0 && init_n_oe_o == $past(init_req_i)))
    else $error("initialise pin not open-drain");
  AST_DRV_SYNC: assert property (
    $rose(drive) && ce_i && port_enable_o |=> (port_drive_enable_o && port_data_oe_o))
    else $error("drive enable lags the data enable");

  COV_SPP_WRITE: cover property (state == ST_SPP_HOLD ##1 done_o);
  COV_EPP_READ: cover property (rd_valid_o && epp_q);
  COV_EPP_TIMEOUT: cover property (timeout_o);
  COV_FIFO_FULL: cover property (!cmd_ready_o && port_enable_o);
endmodule
`default_nettype wire

// ==== sim/lpp_periph.sv ====
// printer-side model of the parallel port for the bench
`timescale 1ns/100ps
`default_nettype none
// ========
// peripheral model
module lpp_periph (
  input wire logic clk_sys_i,
  input wire logic epp_i,
  input wire logic mute_i,
  input wire logic stall_i,
  input wire logic [3:0] st_i,
  input wire logic sel_n_i,
  input wire logic lf_n_i,
  input wire logic stb_n_i,
  input wire logic dir_i,
  input wire logic [7:0] pd_o_i,
  input wire logic pd_oe_i,
  output logic [7:0] pd_i_o,
  output logic att_n_o,
  output logic busy_o,
  output logic [2:0] stat_o,
  output logic [7:0] got_o,
  output logic [1:0] cyc_o
);
  logic [7:0] last = 8'h00;
  logic rd = 1'b0;
  logic ack = 1'b0;
  int n = 0;
  initial begin
    busy_o = 1'b0;
    got_o = 8'h00;
    cyc_o = 2'h0;
  end
  // status pins follow the levels the bench asks for
  assign stat_o = {st_i[2], st_i[1], ~st_i[0]};
  assign att_n_o = ~(st_i[3] | ack);
  // a released bus shows the inverse of its last value, or a fixed read byte during an EPP read
  assign pd_i_o = pd_oe_i ? pd_o_i : (rd ? (sel_n_i ? 8'hA6 : 8'h5A) : ~last);
  // compatibility latch and busy, EPP interlocked wait
  always @(posedge clk_sys_i) begin
    last <= pd_i_o;
    if (!epp_i) begin
      if (!stb_n_i) begin
        got_o <= pd_i_o;
        busy_o <= 1'b1;
        n <= 20;
      end else if (n > 0) begin
        n <= n - 1;
        ack <= n < 5;
      end else begin
        ack <= 1'b0;
        busy_o <= stall_i;
      end
    end else begin
      ack <= 1'b0;
      if (!sel_n_i || !lf_n_i) begin
        if (n < 6) n <= n + 1;
        rd <= dir_i;
        if (n == 5 && !mute_i) begin
          busy_o <= 1'b1;
          cyc_o <= {sel_n_i, dir_i};
          got_o <= pd_i_o;
        end
      end else begin
        n <= 0;
        busy_o <= 1'b0;
        rd <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// ==== sim/tb.sv ====
// self-checking bench for the parallel port engine
`timescale 1ns/100ps
`default_nettype none
// ========
// bench top
module tb;
  import lpp_pkg::*;
  logic clk_sys_i = 1'b0;
  logic rstn_i = 1'b0;
  logic strap = 1'b1, epp = 1'b0, sel = 1'b0, ini = 1'b0, lf = 1'b0, vld = 1'b0;
  logic mute = 1'b0, stall = 1'b0;
  logic [3:0] st = 4'h0;
  lpp_op_t op = LPP_OP_SPP_WR;
  logic [7:0] dat = 8'h00;
  logic rdy, done, tmo, rdv, pen, pe, onl, flt, att, evt, att_n, busy;
  logic hs_o, hs_oe, in_o, in_oe, lf_o, lf_oe, st_o, st_oe, pd_oe, pde, nrdy;
  logic [1:0] epp_d = 2'b00;
  logic [7:0] rdd, pd_i, pd_o, got;
  logic [2:0] stat;
  logic [1:0] cyc;
  int n_errors = 0, samples_checked = 0, n_evt = 0, n_rdv = 0;
  initial forever #5 clk_sys_i = ~clk_sys_i;
  lpp_port DUT (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .ce_i(1'b1), .mode_strap_i(strap),
    .epp_mode_i(epp), .select_req_i(sel), .init_req_i(ini), .auto_linefeed_i(lf),
    .cmd_valid_i(vld), .cmd_op_i(op), .cmd_data_i(dat), .cmd_ready_o(rdy), .done_o(done),
    .timeout_o(tmo), .rd_valid_o(rdv), .rd_data_o(rdd), .port_enable_o(pen), .paper_out_o(pe),
    .online_o(onl), .fault_o(flt), .not_ready_o(nrdy), .attention_o(att), .attention_evt_o(evt),
    .epp_attention_n_i(att_n), .paper_out_i(stat[2]), .wait_busy_i(busy),
    .peripheral_online_i(stat[1]), .fault_n_i(stat[0]), .host_select_n_o(hs_o),
    .host_select_n_oe_o(hs_oe), .init_n_o(in_o), .init_n_oe_o(in_oe), .auto_linefeed_n_o(lf_o),
    .auto_linefeed_n_oe_o(lf_oe), .data_latch_strobe_n_o(st_o), .data_latch_strobe_n_oe_o(st_oe),
    .port_data_i(pd_i), .port_data_o(pd_o), .port_data_oe_o(pd_oe), .port_drive_enable_o(pde));
  // the model sees the mode as it reaches the pins, two registers after the bench sets it
  always @(posedge clk_sys_i) epp_d <= {epp_d[0], epp};
  lpp_periph PER (.clk_sys_i(clk_sys_i), .epp_i(epp_d[1]), .mute_i(mute), .stall_i(stall), .st_i(st),
    .sel_n_i(hs_oe ? hs_o : 1'b1), .lf_n_i(lf_oe ? lf_o : 1'b1), .stb_n_i(st_oe ? st_o : 1'b1),
    .dir_i(st_oe ? st_o : 1'b1), .pd_o_i(pd_o), .pd_oe_i(pd_oe), .pd_i_o(pd_i),
    .att_n_o(att_n), .busy_o(busy), .stat_o(stat), .got_o(got), .cyc_o(cyc));
  // ========
  // shared tasks
  task automatic check(input logic [7:0] g, input logic [7:0] e);
    samples_checked++;
    if (g !== e) begin
      n_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask
  task automatic finish_test();
    $display("checks %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic send(input lpp_op_t o, input logic [7:0] d);
    int k;
    k = 0;
    vld = 1'b1;
    op = o;
    dat = d;
    while (rdy !== 1'b1 && k < 4000) begin tick(1); k++; end
    if (k == 4000) begin
      n_errors++;
      finish_test();
    end else begin
      tick(1);
      vld = 1'b0;
    end
  endtask
  task automatic wait_done();
    int k;
    k = 0;
    while (done !== 1'b1 && k < 4000) begin tick(1); k++; end
    if (k == 4000) begin
      n_errors++;
      finish_test();
    end else begin
      tick(1);
    end
  endtask
  // drive enable and data output enable never disagree
  always @(negedge clk_sys_i) if (rstn_i) check({7'h00, pde}, {7'h00, pd_oe});
  // count attention edges and read data pulses
  always @(posedge clk_sys_i) begin
    if (evt === 1'b1) n_evt++;
    if (rdv === 1'b1) n_rdv++;
  end
  // ========
  // scenarios
  task automatic t_ctrl();
    for (int e = 0; e < 2; e++) begin
      epp = e[0];
      {sel, ini, lf} = 3'h7;
      tick(4);
      check({2'h0, hs_o, hs_oe, in_o, in_oe, lf_o, lf_oe}, e ? 8'h37 : 8'h15);
      {sel, ini, lf} = 3'h0;
      tick(4);
      check({2'h0, hs_o, hs_oe, in_o, in_oe, lf_o, lf_oe}, e ? 8'h3F : 8'h00);
    end
    $display("test ctrl done");
  endtask
  task automatic t_status();
    for (int e = 0; e < 2; e++) begin
      epp = e[0];
      st = 4'hF;
      tick(4);
      check({4'h0, att, pe, onl, flt}, 8'h0F);
      st = 4'h0;
      tick(4);
      check({4'h0, att, pe, onl, flt}, 8'h00);
    end
    $display("test status done");
  endtask
  task automatic t_spp();
    int e0;
    int r0;
    e0 = n_evt;
    epp = 1'b0;
    tick(2);
    send(LPP_OP_SPP_WR, 8'hA5);
    tick(1);
    send(LPP_OP_EPP_AWR, 8'h3C);
    wait_done();
    check(got, 8'hA5);
    wait_done();
    check(got, 8'h3C);
    check(8'(n_evt - e0), 8'h02);
    r0 = n_rdv;
    send(LPP_OP_EPP_DRD, 8'h00);
    wait_done();
    check(8'(n_rdv - r0), 8'h01);
    check({7'h00, pd_oe}, 8'h00);
    $display("test spp done");
  endtask
  task automatic t_epp();
    lpp_op_t ops [4] = '{LPP_OP_EPP_DWR, LPP_OP_EPP_AWR, LPP_OP_EPP_DRD, LPP_OP_EPP_ARD};
    logic [1:0] cy [4] = '{2'h2, 2'h0, 2'h3, 2'h1};
    int r0;
    r0 = n_rdv;
    epp = 1'b1;
    tick(2);
    for (int i = 0; i < 4; i++) begin
      send(ops[i], 8'h11 << i);
      wait_done();
      check({6'h00, cyc}, {6'h00, cy[i]});
      check(i < 2 ? got : rdd, i < 2 ? 8'h11 << i : (i == 2 ? 8'hA6 : 8'h5A));
    end
    check(8'(n_rdv - r0), 8'h02);
    $display("test epp done");
  endtask
  task automatic t_tmo();
    logic hit;
    int r0;
    hit = 1'b0;
    r0 = n_rdv;
    mute = 1'b1;
    send(LPP_OP_EPP_DRD, 8'h00);
    repeat (1100) begin if (tmo === 1'b1) hit = 1'b1; tick(1); end
    check({7'h00, hit}, 8'h01);
    check(8'(n_rdv - r0), 8'h00);
    mute = 1'b0;
    $display("test timeout done");
  endtask
  task automatic t_fifo();
    int acc, dn;
    acc = 0;
    dn = 0;
    epp = 1'b0;
    stall = 1'b1;
    op = LPP_OP_SPP_WR;
    tick(30);
    check({7'h00, nrdy}, 8'h01);
    vld = 1'b1;
    repeat (60) begin if (rdy === 1'b1) acc++; tick(1); end
    vld = 1'b0;
    check(acc[7:0], 8'h21);
    stall = 1'b0;
    repeat (8000) begin if (done === 1'b1) dn++; tick(1); end
    check(dn[7:0], 8'h21);
    check({7'h00, nrdy}, 8'h00);
    $display("test fifo done");
  endtask
  task automatic t_strap();
    rstn_i = 1'b0;
    strap = 1'b0;
    tick(5);
    rstn_i = 1'b1;
    tick(3);
    check({5'h00, pen, st_oe, pd_oe}, 8'h00);
    $display("test strap done");
  endtask
  // ========
  // main sequence
  initial begin
    repeat (5) @(posedge clk_sys_i);
    #1;
    check({6'h00, rdy, pd_oe}, 8'h00);
    rstn_i = 1'b1;
    tick(2);
    check({6'h00, pen, rdy}, 8'h03);
    $display("test reset done");
    t_ctrl();
    t_status();
    t_spp();
    t_epp();
    t_tmo();
    t_fifo();
    t_strap();
    finish_test();
  end
endmodule
`default_nettype wire
